//--- include/adc_seq_pkg.sv
// Purpose: shared constants and types for the conversion sequencer
// Assumes: 32-bit ahb-lite register bus, one word per register
// Notes:   register offsets are byte addresses
package adc_seq_pkg;
  localparam logic [7:0] off_result_high      = 8'h00;
  localparam logic [7:0] off_result_low       = 8'h04;
  localparam logic [7:0] off_main_control     = 8'h08;
  localparam logic [7:0] off_pin_ref_config   = 8'h0C;
  localparam logic [7:0] off_timing_config    = 8'h10;
  localparam logic [7:0] off_status           = 8'h14;
  localparam logic [7:0] off_trigger_config   = 8'h18;
  // main control fields
  localparam int         pos_offset_cal       = 7;
  localparam int         pos_channel_lsb      = 2;
  localparam int         pos_convert_flag     = 1;
  localparam int         pos_converter_on     = 0;
  localparam logic [7:0] main_control_mask    = 8'hBF;
  localparam logic [7:0] pin_ref_mask         = 8'h3F;
  localparam logic [7:0] timing_mask          = 8'hBF;
  localparam logic [7:0] reset_control        = 8'h00;
  // timing config fields
  localparam int         pos_result_justify   = 7;
  localparam int         pos_acq_lsb          = 3;
  localparam logic [3:0] trigger_mode_code    = 4'hB;
  localparam logic [3:0] conv_bit_periods     = 4'hB;
  localparam logic [1:0] post_wait_periods    = 2'h2;
  localparam logic [5:0] rc_start_delay       = 6'h04;
  // a 20 MHz clock gives a 200 ns instruction cycle (4 clocks)
  localparam int         clock_mhz            = 20;
  localparam int         instr_cycle_ns       = 200;
  localparam int         instr_cycle_clocks   = (instr_cycle_ns * clock_mhz + 999) / 1000;

  typedef enum logic [4:0] {
    st_idle    = 5'b00001,
    st_delay   = 5'b00010,
    st_acquire = 5'b00100,
    st_convert = 5'b01000,
    st_wait    = 5'b10000
  } seq_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
  } bus_req_t;
endpackage : adc_seq_pkg

//--- verilog/bit_period_gen.sv
// Purpose: conversion bit-period enable generator
// Assumes: rc_clock_tick is a one-cycle pulse synchronous to hclk
// Notes:   restart clears the divider so the first period is full
`timescale 1ns/100ps
module bit_period_gen (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       restart,
  input  wire logic [2:0] conv_clock_select,
  input  wire logic       rc_clock_tick,
  output logic            period_tick
);
  logic [5:0] count;
  logic [5:0] limit;
  wire        use_rc = (conv_clock_select[1:0] == 2'h3);

  // 000=2,100=4,001=8,101=16,010=32,110=64 oscillator periods
  always_comb begin
    unique case ({conv_clock_select[1:0], conv_clock_select[2]})
      3'h0:    limit = 6'h01;
      3'h1:    limit = 6'h03;
      3'h2:    limit = 6'h07;
      3'h3:    limit = 6'h0F;
      3'h4:    limit = 6'h1F;
      3'h5:    limit = 6'h3F;
      default: limit = 6'h3F;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count       <= 6'h00;
      period_tick <= 1'b0;
    end else if (restart) begin
      count       <= 6'h00;
      period_tick <= 1'b0;
    end else if (use_rc) begin
      period_tick <= rc_clock_tick;
    end else begin
      period_tick <= (count == limit);
      count       <= (count == limit) ? 6'h00 : count + 6'h01;
    end
  end
endmodule : bit_period_gen

//--- verilog/adc_conversion_sequencer.sv
// Purpose: sequencer for a 10-bit successive-approximation converter
// Assumes: comparator decision from the analog front end is synchronous
// Notes:   ahb-lite slave, zero wait states, okay response
`timescale 1ns/100ps
module adc_conversion_sequencer #(
  parameter int pin_count = 16
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 rc_clock_tick,
  input  wire logic                 comparator_high,
  input  wire logic                 compare_two_event,
  input  wire logic [3:0]           compare_two_mode_field,
  input  wire logic [pin_count-1:0] port_pins_in,
  input  wire logic [pin_count-1:0] analog_pin_map,
  output logic [pin_count-1:0]      port_read_value,
  output logic                      timer_counter_clear,
  output logic                      conv_done_flag,
  output logic                      sampling,
  output logic                      calibrating,
  output logic [3:0]                channel_select
);
  if (pin_count < 1 || pin_count > 32) begin : g_bad_pin_count
    $error("pin_count out of range");
  end

  adc_seq_pkg::seq_state_t state;
  adc_seq_pkg::bus_req_t   req;
  logic                    req_valid;
  logic [7:0]              main_ctl;
  logic [7:0]              pin_cfg;
  logic [7:0]              timing_cfg;
  logic [9:0]              result;
  logic [9:0]              sar;
  logic [9:0]              offset_val;
  logic                    cal_run;
  logic [4:0]              tad_count;
  logic [1:0]              delay_count;
  logic [5:0]              rc_delay;
  logic                    period_tick;

  wire       addr_phase  = hsel & htrans[1] & hready;
  wire       wr_data     = req_valid & req.write;
  wire       converter_on = main_ctl[adc_seq_pkg::pos_converter_on];
  wire       convert_flag = main_ctl[adc_seq_pkg::pos_convert_flag];
  wire [2:0] acq_time_select = timing_cfg[adc_seq_pkg::pos_acq_lsb +: 3];
  wire [2:0] conv_clock_select = timing_cfg[2:0];
  wire       rc_selected = (conv_clock_select[1:0] == 2'h3);
  wire       wr_main     = wr_data && req.addr == adc_seq_pkg::off_main_control;
  wire       wr_high     = wr_data && req.addr == adc_seq_pkg::off_result_high;
  wire       wr_low      = wr_data && req.addr == adc_seq_pkg::off_result_low;
  wire       sw_go_set   = wr_main & hwdata[adc_seq_pkg::pos_convert_flag] & ~convert_flag & converter_on;
  wire       trig_go     = compare_two_event && compare_two_mode_field == adc_seq_pkg::trigger_mode_code
                           && converter_on;
  wire       go_rise     = (sw_go_set | trig_go) & (state == adc_seq_pkg::st_idle);
  wire       sw_abort    = wr_main & ~hwdata[adc_seq_pkg::pos_convert_flag];
  // gated by the flag so an abort in the last period loads nothing
  wire       conv_end    = (state == adc_seq_pkg::st_convert) && period_tick && convert_flag
                           && tad_count == 5'(adc_seq_pkg::conv_bit_periods) - 5'h01;
  wire [9:0] bit_mask    = 10'h200 >> tad_count[3:0];
  wire [9:0] corrected   = (sar >= offset_val) ? sar - offset_val : 10'h000;
  wire [15:0] justified  = timing_cfg[adc_seq_pkg::pos_result_justify] ? {6'h00, result}
                           : {result, 6'h00};
  wire       restart_tad = go_rise;

  // acquisition field in bit periods
  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    unique case (code)
      3'h0: acq_periods = 5'd0;
      3'h1: acq_periods = 5'd2;
      3'h2: acq_periods = 5'd4;
      3'h3: acq_periods = 5'd6;
      3'h4: acq_periods = 5'd8;
      3'h5: acq_periods = 5'd12;
      3'h6: acq_periods = 5'd16;
      3'h7: acq_periods = 5'd20;
    endcase
  endfunction : acq_periods

  bit_period_gen u_tad (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .restart           (restart_tad),
    .conv_clock_select (conv_clock_select),
    .rc_clock_tick     (rc_clock_tick),
    .period_tick       (period_tick)
  );

  // bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_valid <= 1'b0;
      req       <= '0;
    end else begin
      req_valid <= addr_phase;
      req.addr  <= haddr[7:0];
      req.write <= hwrite;
    end
  end

  // control registers; the convert flag is set only by a start, cleared by the sequencer, by a main control write of 0 or while the converter is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_ctl   <= adc_seq_pkg::reset_control;
      pin_cfg    <= adc_seq_pkg::reset_control;
      timing_cfg <= adc_seq_pkg::reset_control;
    end else begin
      if (wr_main)
        main_ctl <= (hwdata[7:0] & adc_seq_pkg::main_control_mask & 8'hFD) | {6'h00, convert_flag & ~sw_abort, 1'b0};
      if (go_rise)
        main_ctl[adc_seq_pkg::pos_convert_flag] <= 1'b1;
      else if (conv_end || (!converter_on && !wr_main))
        main_ctl[adc_seq_pkg::pos_convert_flag] <= 1'b0;
      if (go_rise && main_ctl[adc_seq_pkg::pos_offset_cal])
        main_ctl[adc_seq_pkg::pos_offset_cal] <= 1'b0;
      if (wr_data && req.addr == adc_seq_pkg::off_pin_ref_config)
        pin_cfg <= hwdata[7:0] & adc_seq_pkg::pin_ref_mask;
      if (wr_data && req.addr == adc_seq_pkg::off_timing_config)
        timing_cfg <= hwdata[7:0] & adc_seq_pkg::timing_mask;
    end
  end

  // result pair has no reset: unchanged by power-on reset
  always_ff @(posedge hclk) begin
    if (conv_end && !cal_run)
      result <= corrected;
    else if (wr_high)
      result <= timing_cfg[7] ? {hwdata[1:0], result[7:0]} : {hwdata[7:0], result[1:0]};
    else if (wr_low)
      result <= timing_cfg[7] ? {result[9:8], hwdata[7:0]} : {result[9:2], hwdata[7:6]};
  end

  // sequencer; channel and pin direction have no say here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= adc_seq_pkg::st_idle;
      tad_count   <= 5'h00;
      delay_count <= 2'h0;
      rc_delay    <= 6'h00;
      sar         <= 10'h000;
      cal_run     <= 1'b0;
      offset_val  <= 10'h000;
    end else begin
      unique case (state)
        adc_seq_pkg::st_idle: begin
          if (go_rise) begin
            cal_run   <= main_ctl[adc_seq_pkg::pos_offset_cal];
            tad_count <= 5'h00;
            sar       <= 10'h000;
            rc_delay  <= rc_selected ? adc_seq_pkg::rc_start_delay : 6'h00;
            if (acq_time_select == 3'h0)
              state <= adc_seq_pkg::st_delay;
            else
              state <= adc_seq_pkg::st_acquire;
          end
        end
        adc_seq_pkg::st_delay: begin
          if (!convert_flag) state <= adc_seq_pkg::st_wait;
          else if (rc_delay == 6'h00 || rc_delay == 6'h01) begin
            state <= adc_seq_pkg::st_convert;
            sar   <= 10'h200;
          end else
            rc_delay <= rc_delay - 6'h01;
        end
        adc_seq_pkg::st_acquire: begin
          if (!convert_flag) begin
            state <= adc_seq_pkg::st_wait;
            tad_count <= 5'h00;
          end else if (period_tick) begin
            if (tad_count == acq_periods(acq_time_select) - 5'h01) begin
              state     <= adc_seq_pkg::st_convert;
              tad_count <= 5'h00;
              sar       <= 10'h200;
            end else
              tad_count <= tad_count + 5'h01;
          end
        end
        adc_seq_pkg::st_convert: begin
          if (!convert_flag) begin
            state     <= adc_seq_pkg::st_wait;
            tad_count <= 5'h00;
          end else if (period_tick) begin
            if (tad_count < 5'd10) begin
              sar   <= (comparator_high ? sar : sar & ~bit_mask)
                       | (tad_count < 5'd9 ? (bit_mask >> 1) : 10'h000);
            end
            if (conv_end) begin
              if (cal_run) offset_val <= sar;
              state     <= adc_seq_pkg::st_wait;
              tad_count <= 5'h00;
            end else
              tad_count <= tad_count + 5'h01;
          end
        end
        adc_seq_pkg::st_wait: begin
          if (period_tick) begin
            if (tad_count[1:0] == adc_seq_pkg::post_wait_periods - 2'h1) begin
              state <= adc_seq_pkg::st_idle;
              cal_run <= 1'b0;
            end else
              tad_count <= tad_count + 5'h01;
          end
        end
        default: state <= adc_seq_pkg::st_idle;
      endcase
    end
  end

  // read data decoded in the address phase so it stands in the data phase
  wire [7:0] rd_byte =
    (haddr[7:0] == adc_seq_pkg::off_result_high)    ? justified[15:8] :
    (haddr[7:0] == adc_seq_pkg::off_result_low)     ? justified[7:0]  :
    (haddr[7:0] == adc_seq_pkg::off_main_control)   ? main_ctl        :
    (haddr[7:0] == adc_seq_pkg::off_pin_ref_config) ? pin_cfg         :
    (haddr[7:0] == adc_seq_pkg::off_timing_config)  ? timing_cfg      :
    (haddr[7:0] == adc_seq_pkg::off_status)         ? {3'h0, state}   : 8'h00;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata              <= 32'h0000_0000;
      hreadyout           <= 1'b1;
      hresp               <= 1'b0;
      conv_done_flag      <= 1'b0;
      timer_counter_clear <= 1'b0;
      port_read_value     <= '0;
      sampling            <= 1'b0;
      calibrating         <= 1'b0;
      channel_select      <= 4'h0;
    end else begin
      if (addr_phase)
        hrdata            <= {24'h000000, rd_byte};
      timer_counter_clear <= compare_two_event && compare_two_mode_field == adc_seq_pkg::trigger_mode_code;
      if (conv_end) conv_done_flag <= 1'b1;
      else if (wr_data && req.addr == adc_seq_pkg::off_status && hwdata[7]) conv_done_flag <= 1'b0;
      port_read_value     <= port_pins_in & ~analog_pin_map;
      sampling            <= converter_on && state != adc_seq_pkg::st_convert;
      calibrating         <= cal_run;
      channel_select      <= main_ctl[adc_seq_pkg::pos_channel_lsb +: 4];
    end
  end

  // checks on what the sequencer drives
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_conv_last;
    (state == adc_seq_pkg::st_convert) && conv_end;
  endsequence
  sequence s_acq_last;
    (state == adc_seq_pkg::st_acquire) && convert_flag && period_tick
      && tad_count == acq_periods(acq_time_select) - 5'h01;
  endsequence
  sequence s_trigger_seen;
    compare_two_event && compare_two_mode_field == adc_seq_pkg::trigger_mode_code;
  endsequence

  a_done_sets_flag: assert property (s_conv_last |=> conv_done_flag)
    else $error("done flag not set after conversion");
  a_end_clears_go: assert property (s_conv_last |=> !convert_flag)
    else $error("convert flag not cleared after conversion");
  a_end_loads_result: assert property ((conv_end && !cal_run) |=> result == $past(corrected))
    else $error("result not loaded at completion");
  a_abort_keeps_result: assert property ((state == adc_seq_pkg::st_convert && !convert_flag
    && !wr_high && !wr_low) |=> $stable(result))
    else $error("result changed by aborted conversion");
  a_acq_to_convert: assert property (s_acq_last |=> state == adc_seq_pkg::st_convert)
    else $error("conversion did not follow acquisition");
  a_wait_to_idle: assert property ((state == adc_seq_pkg::st_wait && period_tick
    && tad_count[1:0] == 2'h1) |=> state == adc_seq_pkg::st_idle)
    else $error("post-conversion wait not two periods");
  a_trigger_clears_timer: assert property (s_trigger_seen |=> timer_counter_clear)
    else $error("timer clear missing after trigger");
  a_port_reads_low: assert property (1'b1 |=> (port_read_value & $past(analog_pin_map)) == '0)
    else $error("analog pin read high");
endmodule : adc_conversion_sequencer

//--- tb/front_end_model.sv
// Purpose: analog front end and compare unit stand-in
// Assumes: keep_level fixes every comparator decision
// Notes:   rc tick runs free, one pulse every rc_div clocks
`timescale 1ns/100ps
module front_end_model #(
  parameter int rc_div = 8
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic keep_level,
  input  wire logic fire,
  output logic      comparator_high,
  output logic      rc_clock_tick,
  output logic      compare_two_event
);
  logic [7:0] rc_count;
  // one level for all trial bits: result is all ones or all zeros
  assign comparator_high = keep_level;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_count          <= 8'h00;
      rc_clock_tick     <= 1'b0;
      compare_two_event <= 1'b0;
    end else begin
      rc_count          <= (rc_count == 8'(rc_div - 1)) ? 8'h00 : rc_count + 8'h01;
      rc_clock_tick     <= (rc_count == 8'(rc_div - 1));
      compare_two_event <= fire; // one-cycle trigger pulse
    end
  end
endmodule : front_end_model

//--- tb/adc_conversion_sequencer_tb.sv
// Purpose: register-level bench for the conversion sequencer
// Assumes: zero-wait ahb-lite slave, hready looped from hreadyout
// Notes:   span bounds allow a few clocks of start and bus latency
`timescale 1ns/100ps
module adc_conversion_sequencer_tb;
  logic        hclk = 1'b0, hresetn, hsel, hwrite, keep_level, fire;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  compare_two_mode_field, channel_select;
  logic [15:0] port_pins_in, analog_pin_map, port_read_value;
  logic        hreadyout, hresp, rc_clock_tick, comparator_high, compare_two_event;
  logic        timer_counter_clear, conv_done_flag, sampling, calibrating;
  int          err_count = 0, total_checks = 0, clear_count = 0, cyc, n;
  int          acq [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  logic [2:0]  csel [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int          cdiv [7] = '{2, 4, 8, 16, 32, 64, 8};

  always #25 hclk = ~hclk;
  always @(posedge hclk) if (timer_counter_clear === 1'b1) clear_count <= clear_count + 1;

  adc_conversion_sequencer #(.pin_count(16)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rc_clock_tick(rc_clock_tick), .comparator_high(comparator_high), .compare_two_event(compare_two_event),
    .compare_two_mode_field(compare_two_mode_field), .port_pins_in(port_pins_in),
    .analog_pin_map(analog_pin_map), .port_read_value(port_read_value),
    .timer_counter_clear(timer_counter_clear), .conv_done_flag(conv_done_flag), .sampling(sampling),
    .calibrating(calibrating), .channel_select(channel_select));
  front_end_model #(.rc_div(8)) i_front (.hclk(hclk), .hresetn(hresetn), .keep_level(keep_level), .fire(fire),
    .comparator_high(comparator_high), .rc_clock_tick(rc_clock_tick), .compare_two_event(compare_two_event));

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val
  task automatic check_span(input string name, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : check_span
  task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check_val(name, {8'h00, exp}, q[15:0]);
  endtask : rdchk
  task automatic wait_idle;
    logic [31:0] q;
    int k;
    k = 0;
    do begin
      bus(1'b0, adc_seq_pkg::off_status, 32'h0, q);
      k++;
    end while (q[4:0] !== adc_seq_pkg::st_idle && k < 200);
    if (k >= 200) err_count++;
  endtask : wait_idle
  task automatic run_conv(input logic [7:0] timing, output int c);
    wr(adc_seq_pkg::off_status, 32'h80);
    wr(adc_seq_pkg::off_timing_config, {24'h0, timing});
    wr(adc_seq_pkg::off_main_control, 32'h01);
    wr(adc_seq_pkg::off_main_control, 32'h03); // go only in a later write
    c = 0;
    while (conv_done_flag !== 1'b1 && c < 4000) begin
      @(posedge hclk);
      c++;
    end
    wait_idle;
  endtask : run_conv
  task automatic pulse_fire;
    @(posedge hclk) fire <= 1'b1;
    @(posedge hclk) fire <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : pulse_fire
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (30000) @(posedge hclk);
    err_count++;
    wrap_up;
  end

  initial begin
    {hsel, hwrite, fire, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    keep_level = 1'b1;
    compare_two_mode_field = 4'hB;
    port_pins_in = 16'hFFFF;
    analog_pin_map = 16'h00F0;
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("main reset", adc_seq_pkg::off_main_control, 8'h00);
    rdchk("timing reset", adc_seq_pkg::off_timing_config, 8'h00);
    rdchk("unmapped", 8'h40, 8'h00);
    check_val("port read", 16'hFF0F, port_read_value);
    check_val("hresp", 16'h0, {15'h0, hresp});
    wr(adc_seq_pkg::off_main_control, 32'h03);
    rdchk("go with enable", adc_seq_pkg::off_main_control, 8'h01);
    for (int i = 0; i < 8; i++) begin
      run_conv(8'(i << 3), cyc);
      check_span("acq span", 2 * (11 + acq[i]), 2 * (11 + acq[i]) + 10, cyc);
    end
    rdchk("left high", adc_seq_pkg::off_result_high, 8'hFF);
    rdchk("left low", adc_seq_pkg::off_result_low, 8'hC0);
    for (int i = 0; i < 7; i++) begin
      run_conv({5'b10000, csel[i]}, cyc);
      check_span("conv span", 10 * cdiv[i], 13 * cdiv[i] + 14, cyc);
      check_val("sampling", 16'h1, {15'h0, sampling});
      rdchk("right high", adc_seq_pkg::off_result_high, 8'h03);
      rdchk("right low", adc_seq_pkg::off_result_low, 8'hFF);
      rdchk("go cleared", adc_seq_pkg::off_main_control, 8'h01);
    end
    keep_level <= 1'b0;
    wr(adc_seq_pkg::off_status, 32'h80);
    wr(adc_seq_pkg::off_timing_config, 32'h86);
    wr(adc_seq_pkg::off_main_control, 32'h03);
    repeat (300) @(posedge hclk);
    wr(adc_seq_pkg::off_main_control, 32'h01);
    wait_idle;
    check_val("done on abort", 16'h0, {15'h0, conv_done_flag});
    rdchk("kept high", adc_seq_pkg::off_result_high, 8'h03);
    rdchk("kept low", adc_seq_pkg::off_result_low, 8'hFF);
    wr(adc_seq_pkg::off_main_control, 32'h03);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk) hresetn <= 1'b1;
    rdchk("main mid reset", adc_seq_pkg::off_main_control, 8'h00);
    rdchk("result over reset", adc_seq_pkg::off_result_high, 8'hFF);
    wr(adc_seq_pkg::off_timing_config, 32'h86);
    pulse_fire;
    check_val("clear while off", 16'h1, 16'(clear_count));
    rdchk("go while off", adc_seq_pkg::off_main_control, 8'h00);
    wr(adc_seq_pkg::off_main_control, 32'h3D);
    pulse_fire;
    rdchk("go by trigger", adc_seq_pkg::off_main_control, 8'h3F);
    check_val("clear while on", 16'h2, 16'(clear_count));
    check_val("channel", 16'hF, {12'h0, channel_select});
    n = 0;
    while (conv_done_flag !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    check_val("done by trigger", 16'h1, {15'h0, conv_done_flag});
    wait_idle;
    compare_two_mode_field <= 4'hA;
    pulse_fire;
    check_val("other mode", 16'h2, 16'(clear_count));
    rdchk("no go other mode", adc_seq_pkg::off_main_control, 8'h3D);
    wr(adc_seq_pkg::off_main_control, 32'h81);
    wr(adc_seq_pkg::off_main_control, 32'h83);
    n = 0;
    while (calibrating !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    check_val("calibrating", 16'h1, {15'h0, calibrating});
    wrap_up;
  end
endmodule : adc_conversion_sequencer_tb
